// ---- rtl/frhc_hazard_ctrl.sv ----
// Purpose: Fast register conflict detection, operand forwarding and index repeat control
// Assumes: Strobes come from logic on clk; phase events occur on the clock that enters a phase
// Notes: Memory, ending-pulse storage and B-adder live outside; this block only issues pulses
// How it works
// - Fast register slots one microsecond apart
// - Slots: index t3, A t5, result t7, M t1
// - Selector storage holds result address until the next result load
// - Compare stored result address with later addresses
// - Unequal proceeds; equal alters sequencing
// - Checks: n+1 index t7, M t1, n+2 t3, A t5
// - t7 index check uses first instruction register
// - A input: fast register or forwarded result
// - No parity strobe on forwarded operands
// - M unequal: fast register in, parity checked unless A forwarded
// - M equal: result into M input at t7
// - t2 load puts index digits in both registers
// - Modification active: t3,t7 set eq or neq
// - Every index conflict stalls and repeats modification
// - t3 equality flags at t4, pulse at t0
// - Repeat pulse: plus zero, clear call, store, block
// - Block busy at t1, request counter clear
// - No inequality at t1 holds first register
// - Equality flag through t2 blocks t7 inequality
// - Two-back conflict stalls exactly one cycle
// - One-back conflict flags equality at t0
// - One-back conflict repeats, two cycles total
`timescale 1ns/1ps
module frhc_hazard_ctrl
  import frhc_pkg::*;
#(
  parameter int ADDR_W = 7,
  parameter int DATA_W = 12
)(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Instruction sequencing inputs
  input wire logic instruction_load_strobe,
  input wire logic modify_next_strobe,
  input wire logic [ADDR_W-1:0] index_digits,
  input wire logic [ADDR_W-1:0] a_operand_addr,
  input wire logic [ADDR_W-1:0] m_operand_addr,
  input wire logic m_is_fast_reg,
  input wire logic result_addr_load,
  input wire logic [ADDR_W-1:0] result_addr,
  input wire logic memory_not_busy,
  // Operand data
  input wire logic [DATA_W-1:0] fast_reg_data,
  input wire logic [DATA_W-1:0] arith_result_data,
  // Timing and comparator
  output logic [2:0] phase,
  output logic comparator_equal,
  output logic comparator_unequal,
  // Operand chain
  output logic fast_reg_to_a_input_gate,
  output logic result_to_a_input_gate,
  output logic fast_reg_to_m_input_gate,
  output logic result_to_m_input_gate,
  output logic parity_check_strobe,
  output logic a_forward_select_one,
  output logic a_forward_select_two,
  output logic m_forward_select,
  output logic [DATA_W-1:0] a_input_reg,
  output logic [DATA_W-1:0] m_input_reg,
  // Index modification control
  output logic [ADDR_W-1:0] fast_reg_select,
  output logic modification_active_flag,
  output logic index_equality_flag,
  output logic index_inequality_flag,
  output logic repeat_modification_pulse,
  output logic plus_zero_to_b_adder,
  output logic completing_call_clear,
  output logic ending_storage_set,
  output logic block_not_busy_flag,
  output logic counter_clear_request,
  output logic operand_not_busy_signal,
  output logic hold_first_instruction
);
  import frhc_pkg::*;

  function automatic logic at_ph(input logic t, input logic [2:0] p, input logic [2:0] n);
    return t && (p == n);
  endfunction

  logic [DIV_W-1:0] div_reg;
  logic [2:0] phase_reg;
  logic [ADDR_W-1:0] sel_store_reg;
  logic sel_valid_reg;
  logic [ADDR_W-1:0] first_instruction_register;
  logic [ADDR_W-1:0] cmp_addr;
  logic tick, eq;
  logic [2:0] ph_nx;
  logic at_t0, at_t1, at_t2, at_t3, at_t4, at_t5, at_t7;
  logic a_eq_reg, a_neq_reg, m_eq_reg, m_neq_reg;
  logic t3_eq_reg;
  logic idx_set_eq, idx_set_neq;

  assign tick = (div_reg == DIV_LAST);
  assign ph_nx = phase_reg + PH_STEP;
  assign at_t0 = at_ph(tick, ph_nx, PH_T0);
  assign at_t1 = at_ph(tick, ph_nx, PH_T1);
  assign at_t2 = at_ph(tick, ph_nx, PH_T2);
  assign at_t3 = at_ph(tick, ph_nx, PH_T3);
  assign at_t4 = at_ph(tick, ph_nx, PH_T4);
  assign at_t5 = at_ph(tick, ph_nx, PH_T5);
  assign at_t7 = at_ph(tick, ph_nx, PH_T7);

  // Phase timing: access slots sit every other phase, one microsecond apart
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      div_reg <= DIV_RST;
      phase_reg <= PH_T0;
    end
    else if (tick)
    begin
      div_reg <= DIV_RST;
      phase_reg <= ph_nx;
    end
    else
      div_reg <= div_reg + 4'h1;
  end
  assign phase = phase_reg;

  // Selector storage keeps the result address until the next result replaces it
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sel_store_reg <= '0;
      sel_valid_reg <= 1'b0;
    end
    else if (result_addr_load)
    begin
      sel_store_reg <= result_addr;
      sel_valid_reg <= 1'b1;
    end
  end

  // Index digits go to both registers so modification starts at once
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      first_instruction_register <= '0;
      fast_reg_select <= '0;
    end
    else if (at_t2 && instruction_load_strobe)
    begin
      first_instruction_register <= index_digits;
      fast_reg_select <= index_digits;
    end
    else if (at_t2 && modify_next_strobe)
      fast_reg_select <= first_instruction_register;
  end

  // Comparator operand picked by the slot being entered
  always_comb
  begin
    unique case (ph_nx)
      PH_T7: cmp_addr = first_instruction_register;
      PH_T1: cmp_addr = m_operand_addr;
      PH_T5: cmp_addr = a_operand_addr;
      default: cmp_addr = fast_reg_select;
    endcase
  end
  assign eq = sel_valid_reg && (cmp_addr == sel_store_reg);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      comparator_equal <= 1'b0;
      comparator_unequal <= 1'b0;
    end
    else if (tick)
    begin
      comparator_equal <= eq;
      comparator_unequal <= !eq;
    end
  end

  // Operand pairs: set at their slot, spent at t7 and cleared at t0
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      a_eq_reg <= 1'b0;
      a_neq_reg <= 1'b0;
      m_eq_reg <= 1'b0;
      m_neq_reg <= 1'b0;
    end
    else
    begin
      if (at_t5)
      begin
        a_eq_reg <= eq;
        a_neq_reg <= !eq;
      end
      else if (at_t0)
      begin
        a_eq_reg <= 1'b0;
        a_neq_reg <= 1'b0;
      end
      if (at_t1 && m_is_fast_reg)
      begin
        m_eq_reg <= eq;
        m_neq_reg <= !eq;
      end
      else if (at_t0)
      begin
        m_eq_reg <= 1'b0;
        m_neq_reg <= 1'b0;
      end
    end
  end
  assign a_forward_select_one = a_eq_reg;
  assign a_forward_select_two = a_eq_reg;
  assign m_forward_select = m_eq_reg;

  // Forwarding costs no time; parity is only meaningful on fast register reads
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      fast_reg_to_a_input_gate <= 1'b0;
      result_to_a_input_gate <= 1'b0;
      fast_reg_to_m_input_gate <= 1'b0;
      result_to_m_input_gate <= 1'b0;
      parity_check_strobe <= 1'b0;
      a_input_reg <= '0;
      m_input_reg <= '0;
    end
    else
    begin
      fast_reg_to_a_input_gate <= at_t7 && a_neq_reg;
      result_to_a_input_gate <= at_t7 && a_eq_reg;
      fast_reg_to_m_input_gate <= at_t7 && m_neq_reg;
      result_to_m_input_gate <= at_t7 && m_eq_reg;
      parity_check_strobe <= at_t7 && (a_neq_reg || m_neq_reg) && !a_eq_reg && !m_eq_reg;
      if (at_t7 && (a_eq_reg || a_neq_reg))
        a_input_reg <= a_eq_reg ? arith_result_data : fast_reg_data;
      if (at_t7 && (m_eq_reg || m_neq_reg))
        m_input_reg <= m_eq_reg ? arith_result_data : fast_reg_data;
    end
  end

  // Index comparisons; the t7 one is ignored while an equality is still standing
  // The flag is still high on the t3 tick, so only the t7 compare may look at it
  assign idx_set_neq = modification_active_flag && !eq
                       && (at_t3 || (at_t7 && !index_equality_flag));
  assign idx_set_eq = (t3_eq_reg && at_t4) || (modification_active_flag && eq && at_t7
                       && !index_equality_flag);

  always_ff @(posedge clk)
  begin
    if (srst)
      modification_active_flag <= 1'b0;
    else if (at_t2 && (instruction_load_strobe || modify_next_strobe))
      modification_active_flag <= 1'b1;
    else if (at_t0)
      modification_active_flag <= 1'b0;
  end

  // t3 equality waits one phase so the flag rises at t4
  always_ff @(posedge clk)
  begin
    if (srst)
      t3_eq_reg <= 1'b0;
    else if (at_t3)
      t3_eq_reg <= modification_active_flag && eq;
    else if (at_t4)
      t3_eq_reg <= 1'b0;
  end

  // The t7 equality is held in a pending bit and shown from t0
  logic t7_eq_reg;
  always_ff @(posedge clk)
  begin
    if (srst)
      t7_eq_reg <= 1'b0;
    else if (at_t7)
      t7_eq_reg <= idx_set_eq && !t3_eq_reg;
    else if (at_t0)
      t7_eq_reg <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      index_equality_flag <= 1'b0;
      index_inequality_flag <= 1'b0;
    end
    else
    begin
      if (at_t4 && t3_eq_reg)
        index_equality_flag <= 1'b1;
      else if (at_t0 && t7_eq_reg)
        index_equality_flag <= 1'b1;
      else if (at_t3)
        index_equality_flag <= 1'b0;
      if (idx_set_neq)
        index_inequality_flag <= 1'b1;
      else if (at_t2 || (at_t4 && t3_eq_reg) || (at_t0 && t7_eq_reg))
        index_inequality_flag <= 1'b0;
    end
  end

  // Repeat pulse from standing equality at t0; it always costs a cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      repeat_modification_pulse <= 1'b0;
      plus_zero_to_b_adder <= 1'b0;
      completing_call_clear <= 1'b0;
      ending_storage_set <= 1'b0;
    end
    else
    begin
      repeat_modification_pulse <= at_t0 && (index_equality_flag || t7_eq_reg);
      plus_zero_to_b_adder <= at_t0 && (index_equality_flag || t7_eq_reg);
      completing_call_clear <= at_t0 && (index_equality_flag || t7_eq_reg);
      ending_storage_set <= at_t0 && (index_equality_flag || t7_eq_reg);
    end
  end

  // Block-not-busy discards the wrongly modified operand call
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      block_not_busy_flag <= 1'b0;
      counter_clear_request <= 1'b0;
      operand_not_busy_signal <= 1'b0;
      hold_first_instruction <= 1'b0;
    end
    else
    begin
      if (repeat_modification_pulse)
        block_not_busy_flag <= 1'b1;
      else if (at_t2)
        block_not_busy_flag <= 1'b0;
      operand_not_busy_signal <= at_t1 && memory_not_busy && !block_not_busy_flag;
      counter_clear_request <= at_t1 && block_not_busy_flag;
      if (at_t1)
        hold_first_instruction <= !index_inequality_flag;
    end
  end

  // Checks
  property p_fwd_no_parity;
    @(posedge clk) disable iff (srst)
      (result_to_a_input_gate || result_to_m_input_gate) |-> !parity_check_strobe;
  endproperty
  a_fwd_no_parity: assert property (p_fwd_no_parity) else $error("parity strobe on forward");

  property p_a_gate_excl;
    @(posedge clk) disable iff (srst) !(fast_reg_to_a_input_gate && result_to_a_input_gate);
  endproperty
  a_a_gate_excl: assert property (p_a_gate_excl) else $error("both A gates");

  property p_a_fwd_data;
    @(posedge clk) disable iff (srst)
      (at_t7 && a_eq_reg) |=> (result_to_a_input_gate && a_input_reg == $past(arith_result_data));
  endproperty
  a_a_fwd_data: assert property (p_a_fwd_data) else $error("A forward wrong");

  property p_m_fast;
    @(posedge clk) disable iff (srst)
      // One strobe serves both inputs, so a forwarded A operand withholds it
      (at_t7 && m_neq_reg) |=> (fast_reg_to_m_input_gate && (parity_check_strobe || result_to_a_input_gate));
  endproperty
  a_m_fast: assert property (p_m_fast) else $error("M fast path wrong");

  property p_m_fwd;
    @(posedge clk) disable iff (srst)
      (at_t7 && m_eq_reg) |=> (result_to_m_input_gate && m_input_reg == $past(arith_result_data));
  endproperty
  a_m_fwd: assert property (p_m_fwd) else $error("M forward wrong");

  property p_idx_excl;
    @(posedge clk) disable iff (srst) !(idx_set_eq && idx_set_neq);
  endproperty
  a_idx_excl: assert property (p_idx_excl) else $error("index eq and neq together");

  property p_repeat_effects;
    @(posedge clk) disable iff (srst)
      repeat_modification_pulse |-> (plus_zero_to_b_adder && completing_call_clear && ending_storage_set)
      ##1 block_not_busy_flag;
  endproperty
  a_repeat_effects: assert property (p_repeat_effects) else $error("repeat pulse effects missing");

  property p_block;
    @(posedge clk) disable iff (srst) block_not_busy_flag |=> !operand_not_busy_signal;
  endproperty
  a_block: assert property (p_block) else $error("not-busy passed while blocked");

  property p_t3_flag;
    // Written on the t4 tick, 13 clocks on, and seen in the sample after that
    @(posedge clk) disable iff (srst) (at_t3 && modification_active_flag && eq) |-> ##14 $rose(index_equality_flag);
  endproperty
  a_t3_flag: assert property (p_t3_flag) else $error("t3 equality not flagged");

  property p_phase_step;
    @(posedge clk) disable iff (srst) tick |=> (phase_reg == $past(ph_nx));
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase did not advance");
endmodule

// ---- include/frhc_pkg.sv ----
// Purpose: Shared constants for the fast register hazard control block
// Assumes: 25 MHz clock, eight timing phases t0..t7 per 4 us machine cycle
// Notes: Phase boundaries are derived from the clock rate, not hand counted
package frhc_pkg;
  localparam int CLK_NS = 40;
  localparam int CYCLE_NS = 4000;
  localparam int ACCESS_NS = 1000;
  localparam int PHASES = 8;
  localparam int PHASE_NS = CYCLE_NS / PHASES;
  // Least phase time, rounded up to whole clocks
  localparam int PHASE_CLKS = (PHASE_NS + CLK_NS - 1) / CLK_NS;
  // Phases between two fast register accesses
  localparam int ACCESS_PHASES = ACCESS_NS / PHASE_NS;
  localparam int DIV_W = 4;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(PHASE_CLKS - 1);
  localparam logic [DIV_W-1:0] DIV_RST = 4'h0;
  localparam logic [2:0] PH_T0 = 3'h0;
  localparam logic [2:0] PH_T1 = 3'h1;
  localparam logic [2:0] PH_T2 = 3'h2;
  localparam logic [2:0] PH_T3 = 3'h3;
  localparam logic [2:0] PH_T4 = 3'h4;
  localparam logic [2:0] PH_T5 = 3'h5;
  localparam logic [2:0] PH_T6 = 3'h6;
  localparam logic [2:0] PH_T7 = 3'h7;
  localparam logic [2:0] PH_STEP = 3'h1;
endpackage

// ---- verification/frhc_far_side_model.sv ----
// Purpose: Arithmetic unit, fast register store and memory seen from the hazard block
// Assumes: Fixed operand patterns, so the bench can tell forwarded from fetched data
// Notes: Memory answers at once unless the bench asks it to stall
`timescale 1ns/1ps
module frhc_far_side_model
#(
  parameter logic [11:0] FR_DATA = 12'h3C5,
  parameter logic [11:0] ARITH_DATA = 12'hA5C
)(
  // Bench control
  input wire logic mem_busy,
  // Block side
  input wire logic [6:0] fast_reg_select,
  output logic [11:0] fast_reg_data,
  output logic [11:0] arith_result_data,
  output logic memory_not_busy
);
  // Distinct patterns make a wrong gate show up as a wrong word
  assign fast_reg_data = FR_DATA;
  assign arith_result_data = ARITH_DATA;
  assign memory_not_busy = !mem_busy;
endmodule

// ---- verification/fast_register_hazard_control_tb_top.sv ----
// Purpose: Directed checks of forwarding and index repeat sequencing
// Assumes: Inputs change at the falling edge; phase ticks every 13 clocks
// Notes: Each check samples at the first falling edge inside the phase it waits for, except one block flag and one repeat pulse check, one edge later
`timescale 1ns/1ps
module fast_register_hazard_control_tb_top;
  import frhc_pkg::*;
  localparam logic [11:0] FR = 12'h3C5;
  localparam logic [11:0] ARITH = 12'hA5C;
  logic clk = 1'h0, srst = 1'h1, instruction_load_strobe = 1'h0, modify_next_strobe = 1'h0;
  logic m_is_fast_reg = 1'h1, result_addr_load = 1'h0, mem_busy = 1'h0, memory_not_busy;
  logic [6:0] index_digits = 7'h01, a_operand_addr = 7'h02, m_operand_addr = 7'h03;
  logic [6:0] result_addr = 7'h00, fast_reg_select;
  logic [11:0] fast_reg_data, arith_result_data, a_input_reg, m_input_reg;
  logic [2:0] phase;
  logic comparator_equal, comparator_unequal, fast_reg_to_a_input_gate, result_to_a_input_gate;
  logic fast_reg_to_m_input_gate, result_to_m_input_gate, parity_check_strobe;
  logic a_forward_select_one, a_forward_select_two, m_forward_select;
  logic modification_active_flag, index_equality_flag, index_inequality_flag;
  logic repeat_modification_pulse, plus_zero_to_b_adder, completing_call_clear, ending_storage_set;
  logic block_not_busy_flag, counter_clear_request, operand_not_busy_signal, hold_first_instruction;
  int n_fail = 0;
  int tests_run = 0;

  frhc_hazard_ctrl DUT (.clk, .srst, .instruction_load_strobe, .modify_next_strobe, .index_digits,
    .a_operand_addr, .m_operand_addr, .m_is_fast_reg, .result_addr_load, .result_addr, .memory_not_busy,
    .fast_reg_data, .arith_result_data, .phase, .comparator_equal, .comparator_unequal,
    .fast_reg_to_a_input_gate, .result_to_a_input_gate, .fast_reg_to_m_input_gate,
    .result_to_m_input_gate, .parity_check_strobe, .a_forward_select_one, .a_forward_select_two,
    .m_forward_select, .a_input_reg, .m_input_reg, .fast_reg_select, .modification_active_flag,
    .index_equality_flag, .index_inequality_flag, .repeat_modification_pulse, .plus_zero_to_b_adder,
    .completing_call_clear, .ending_storage_set, .block_not_busy_flag, .counter_clear_request,
    .operand_not_busy_signal, .hold_first_instruction);

  frhc_far_side_model far (.mem_busy, .fast_reg_select, .fast_reg_data, .arith_result_data, .memory_not_busy);

  initial
  begin
    forever #20 clk = ~clk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait at falling edges until the phase output shows p
  task automatic at(input logic [2:0] p);
    int k;
    k = 0;
    while (phase !== p && k < 200)
    begin
      @(negedge clk);
      k++;
    end
    if (k >= 200)
    begin
      n_fail++;
      $display("wrong value at %0t: phase never reached", $time);
    end
  endtask

  // Registered answers change on the phase tick itself, and pulses last one clock only
  task automatic after(input logic [2:0] p);
    at(p);
  endtask

  // Strobe held through the tick that enters t2
  task automatic load(input logic again);
    at(PH_T1);
    instruction_load_strobe = !again;
    modify_next_strobe = again;
    at(PH_T2);
    instruction_load_strobe = 1'h0;
    modify_next_strobe = 1'h0;
  endtask

  task automatic set_result(input logic [6:0] r);
    result_addr = r;
    result_addr_load = 1'h1;
    @(negedge clk);
    result_addr_load = 1'h0;
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  initial
  begin
    repeat (5) @(negedge clk);
    srst = 1'h0;
    chk(phase, PH_T0);
    chk(block_not_busy_flag, 1'h0);
    set_result(7'h2A);
    a_operand_addr = 7'h2A;
    after(PH_T5); chk(comparator_equal, 1'h1);
    chk(a_forward_select_one, 1'h1);
    chk(a_forward_select_two, 1'h1);
    after(PH_T7); chk(result_to_a_input_gate, 1'h1);
    chk(fast_reg_to_a_input_gate, 1'h0);
    chk(parity_check_strobe, 1'h0);
    chk(a_input_reg, ARITH);
    done("a_forward");
    a_operand_addr = 7'h02;
    m_operand_addr = 7'h2A;
    after(PH_T1); chk(m_forward_select, 1'h1);
    chk(comparator_equal, 1'h1);
    after(PH_T7); chk(result_to_m_input_gate, 1'h1);
    chk(fast_reg_to_m_input_gate, 1'h0);
    chk(m_input_reg, ARITH);
    chk(parity_check_strobe, 1'h0);
    done("m_forward");
    m_operand_addr = 7'h03;
    after(PH_T1); chk(comparator_unequal, 1'h1);
    chk(m_forward_select, 1'h0);
    after(PH_T5); chk(a_forward_select_one, 1'h0);
    after(PH_T7); chk(fast_reg_to_a_input_gate, 1'h1);
    chk(fast_reg_to_m_input_gate, 1'h1);
    chk(parity_check_strobe, 1'h1);
    chk(a_input_reg, FR);
    chk(m_input_reg, FR);
    m_is_fast_reg = 1'h0;
    m_operand_addr = 7'h2A;
    mem_busy = 1'h1;
    after(PH_T1); chk(m_forward_select, 1'h0);
    chk(operand_not_busy_signal, 1'h0);
    mem_busy = 1'h0;
    m_is_fast_reg = 1'h1;
    m_operand_addr = 7'h03;
    done("no_conflict");
    index_digits = 7'h2A;
    load(1'h0);
    after(PH_T3); chk(modification_active_flag, 1'h1);
    chk(fast_reg_select, 7'h2A);
    chk(comparator_equal, 1'h1);
    after(PH_T4); chk(index_equality_flag, 1'h1);
    chk(index_inequality_flag, 1'h0);
    after(PH_T7); chk(index_inequality_flag, 1'h0);
    after(PH_T0); chk(repeat_modification_pulse, 1'h1);
    chk(plus_zero_to_b_adder, 1'h1);
    chk(completing_call_clear, 1'h1);
    chk(ending_storage_set, 1'h1);
    @(negedge clk); chk(block_not_busy_flag, 1'h1);
    chk(repeat_modification_pulse, 1'h0);
    after(PH_T1); chk(counter_clear_request, 1'h1);
    chk(operand_not_busy_signal, 1'h0);
    chk(hold_first_instruction, 1'h1);
    chk(index_equality_flag, 1'h1);
    // Older result now written back, so selector storage moves on
    set_result(7'h55);
    load(1'h1);
    chk(index_equality_flag, 1'h1);
    after(PH_T3); chk(index_inequality_flag, 1'h1);
    chk(index_equality_flag, 1'h0);
    after(PH_T0); chk(repeat_modification_pulse, 1'h0);
    after(PH_T1); chk(operand_not_busy_signal, 1'h1);
    chk(hold_first_instruction, 1'h0);
    done("two_back");
    index_digits = 7'h66;
    load(1'h0);
    after(PH_T3); chk(comparator_unequal, 1'h1);
    at(PH_T6);
    set_result(7'h66);
    after(PH_T7); chk(comparator_equal, 1'h1);
    after(PH_T0); chk(index_equality_flag, 1'h1);
    chk(repeat_modification_pulse, 1'h1);
    chk(index_inequality_flag, 1'h0);
    load(1'h1);
    chk(hold_first_instruction, 1'h1);
    after(PH_T4); chk(index_equality_flag, 1'h1);
    after(PH_T0); chk(repeat_modification_pulse, 1'h1);
    set_result(7'h77);
    load(1'h1);
    after(PH_T3); chk(index_inequality_flag, 1'h1);
    after(PH_T0); chk(repeat_modification_pulse, 1'h0);
    done("one_back");
    close_out;
  end

  // About twelve times the length of the directed sequence
  initial
  begin
    #400000;
    n_fail++;
    close_out;
  end
endmodule
